// [vtr_buf2.v]
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Synchronous active-low reset, clock enable freezes all state
// Notes:   in_ready and out_valid/out_data come straight from flip-flops
`include "vtr_map.vh"

module vtr_buf2 #(
    parameter W = `VTR_DATA_W + 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);

    reg  [W-1:0] head_q;
    reg          head_v_q;
    reg  [W-1:0] skid_q;
    reg          skid_v_q;
    wire         push;
    wire         pop;

    // Handshake terms
    assign push      = in_valid & ~skid_v_q;
    assign pop       = head_v_q & out_ready;
    assign in_ready  = ~skid_v_q;
    assign out_valid = head_v_q;
    assign out_data  = head_q;

    // Head feeds the output, skid catches a word while the reader stalls
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            head_q   <= {W{1'b0}};
            head_v_q <= 1'b0;
            skid_q   <= {W{1'b0}};
            skid_v_q <= 1'b0;
        end
        else if (ce)
        begin
            if (!head_v_q || pop)
            begin
                if (skid_v_q)
                begin
                    head_q   <= skid_q;   // Oldest word first
                    head_v_q <= 1'b1;
                    skid_v_q <= 1'b0;
                end
                else
                begin
                    head_q   <= in_data;
                    head_v_q <= push;
                end
            end
            else if (push)
            begin
                skid_q   <= in_data;      // Reader stalled, park the word
                skid_v_q <= 1'b1;
            end
        end
    end

endmodule

// [vtr_map.vh]
// Purpose: Shared constants for the valid-tagged rate and latency stages
// Assumes: Included by bare name from every design file
// Notes:   Defaults except VTR_CNT_W, VTR_CNT_RST and VTR_ZERO_W; module parameters may override them
`ifndef VTR_MAP_VH
`define VTR_MAP_VH

// Sample word width
`define VTR_DATA_W      16
// Delay line length in sample periods
`define VTR_DLY_LAT     4
// Register stage initial output value
`define VTR_REG_INIT    16'h0000
// Register stage loads only valid samples when 1
`define VTR_REG_KEEP    1'b0
// Down-sampler ratio and zero-initial-output option
`define VTR_DS_K        2
`define VTR_DS_ZERO     1'b0
// Up-sampler ratio and copy option
`define VTR_US_K        2
`define VTR_US_COPY     1'b1
// Phase counter width and its reset value
`define VTR_CNT_W       8
`define VTR_CNT_RST     8'h00
// Idle word of the delay, rate and clearer sample registers
`define VTR_ZERO_W      16'h0000

`endif

// [vtr_monitor.sv]
// Purpose: Concurrent checks on register, rate and delay outputs
// Assumes: Ratios of 2 and copy on; keep-valid from the instance
// Notes:   Bound into every vtr_stages instance
module vtr_monitor #(
    parameter              DATA_W   = 16,
    parameter [DATA_W-1:0] REG_INIT = 16'h0000,
    parameter [0:0]        REG_KEEP = 1'b0
) (
    input wire              CLK_SYS,
    input wire              RST_B,
    input wire              CE,
    input wire [DATA_W-1:0] REG_IN,
    input wire              REG_IN_TAG,
    input wire              REG_CLR,
    input wire [DATA_W-1:0] REG_OUT,
    input wire              REG_OUT_TAG,
    input wire [DATA_W-1:0] DS_OUT,
    input wire              DS_OUT_STB,
    input wire [DATA_W-1:0] US_IN,
    input wire              US_IN_TAKE,
    input wire [DATA_W-1:0] US_OUT,
    input wire [DATA_W-1:0] DLY_OUT,
    input wire              DLY_OUT_AVAIL,
    input wire              DLY_OUT_RDY
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    // Two enabled edges in a row, and a strobe on an enabled edge
    sequence ce_twice;
        CE ##1 CE;
    endsequence
    sequence stb_taken;
        DS_OUT_STB && CE;
    endsequence

    // Register stage
    a_reg_load:
        assert property (CE && !REG_CLR && REG_IN_TAG |=> REG_OUT == $past(REG_IN))
        else $error("register missed its input");
    a_reg_keep:
        assert property (REG_KEEP && CE && !REG_CLR && !REG_IN_TAG |=> $stable(REG_OUT))
        else $error("register loaded an invalid sample");
    a_reg_clear:
        assert property (CE && REG_CLR |=> REG_OUT == REG_INIT && REG_OUT_TAG)
        else $error("register clear missed");
    // Down-sampler
    a_ds_hold:
        assert property (!DS_OUT_STB |-> $stable(DS_OUT))
        else $error("down output changed without strobe");
    a_ds_single:
        assert property (stb_taken |=> !DS_OUT_STB)
        else $error("down strobes too close");
    a_ds_period:
        assert property (ce_twice |=> DS_OUT_STB || $past(DS_OUT_STB))
        else $error("down strobe missing");
    // Up-sampler
    a_us_take:
        assert property (US_IN_TAKE && CE |=> US_OUT == $past(US_IN))
        else $error("up input not taken");
    a_us_copy:
        assert property (CE && !US_IN_TAKE |=> $stable(US_OUT))
        else $error("up copy not held");
    // Delay buffer
    a_dly_hold:
        assert property (DLY_OUT_AVAIL && !DLY_OUT_RDY |=> DLY_OUT_AVAIL && $stable(DLY_OUT))
        else $error("delay word lost in stall");
endmodule

bind vtr_stages vtr_monitor #(
    .DATA_W(DATA_W), .REG_INIT(REG_INIT), .REG_KEEP(REG_KEEP)
) mon_u (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE), .REG_IN(REG_IN),
    .REG_IN_TAG(REG_IN_TAG), .REG_CLR(REG_CLR), .REG_OUT(REG_OUT),
    .REG_OUT_TAG(REG_OUT_TAG), .DS_OUT(DS_OUT), .DS_OUT_STB(DS_OUT_STB),
    .US_IN(US_IN), .US_IN_TAKE(US_IN_TAKE), .US_OUT(US_OUT), .DLY_OUT(DLY_OUT),
    .DLY_OUT_AVAIL(DLY_OUT_AVAIL), .DLY_OUT_RDY(DLY_OUT_RDY)
);

// [vtr_sink.sv]
// Purpose: Reader of the delay output that stalls at random
// Assumes: Ready changes just after the rising edge
// Notes:   Stalls of up to seven cycles fill the buffer and drop its input ready
module vtr_sink (
    input  wire  clk,
    input  wire  rst_b,
    output logic rdy
);
    timeunit 1ns;
    timeprecision 1ns;
    int stall = 0;
    initial rdy = 1'b1;
    // Ready drops for random runs
    always @(posedge clk)
    begin
        rdy <= !rst_b || stall == 0;
        if (stall > 0)
            stall <= stall - 1;
        else if ($urandom_range(3, 0) == 0)
            stall <= $urandom_range(7, 1);
    end
endmodule

// [vtr_stages.v]
// Purpose: Valid-tagged delay, register, rate and valid-flag stages
// Assumes: One system clock CLK_SYS; CE high marks an enabled edge
// Notes:   Every output comes from a flip-flop; tag = companion valid net
// Function
// - Delay line repeats each input after a set number of sample periods.
// - Delay outputs stay flagged invalid until the line has filled.
// - Delay accepts any latency of one or more and has no initial output value.
// - Register stage delays its input by exactly one sample period.
// - Register stage has data and reset inputs; initial value is a parameter.
// - With keep-valid option, register never loads invalid samples.
// - Down-sampler forwards every k-th input and holds it one output period.
// - Down ratio k is at least 2; output period is k input periods.
// - Zero-initial option makes first down output valid zero, else invalid.
// - Up ratio k is at least 2; output period is input period over k.
// - Copy option repeats each input across all its k output periods.
// - Without copy, each input appears once then k-1 zero outputs.
// - Every data word travels with a companion valid flag.
// - Valid reader outputs 1 for a valid input sample, else 0.
// - Valid clearer marks output invalid when control is zero, else passes.
// - Valid clearer never turns an invalid sample into a valid one.
`include "vtr_map.vh"

module vtr_stages #(
    parameter       DATA_W   = `VTR_DATA_W,
    parameter       DLY_LAT  = `VTR_DLY_LAT,
    parameter [DATA_W-1:0] REG_INIT = `VTR_REG_INIT,
    parameter [0:0] REG_KEEP = `VTR_REG_KEEP,
    parameter       DS_K     = `VTR_DS_K,
    parameter [0:0] DS_ZERO  = `VTR_DS_ZERO,
    parameter       US_K     = `VTR_US_K,
    parameter [0:0] US_COPY  = `VTR_US_COPY
) (
    input  wire              CLK_SYS,
    input  wire              RST_B,
    input  wire              CE,
    // Delay line
    input  wire [DATA_W-1:0] DLY_IN,
    input  wire              DLY_IN_TAG,
    output wire              DLY_IN_RDY,
    output wire [DATA_W-1:0] DLY_OUT,
    output wire              DLY_OUT_TAG,
    output wire              DLY_OUT_AVAIL,
    input  wire              DLY_OUT_RDY,
    // Single register stage
    input  wire [DATA_W-1:0] REG_IN,
    input  wire              REG_IN_TAG,
    input  wire              REG_CLR,
    output reg  [DATA_W-1:0] REG_OUT,
    output reg               REG_OUT_TAG,
    // Down-sampler
    input  wire [DATA_W-1:0] DS_IN,
    input  wire              DS_IN_TAG,
    output reg  [DATA_W-1:0] DS_OUT,
    output reg               DS_OUT_TAG,
    output reg               DS_OUT_STB,
    // Up-sampler
    input  wire [DATA_W-1:0] US_IN,
    input  wire              US_IN_TAG,
    output reg               US_IN_TAKE,
    output reg  [DATA_W-1:0] US_OUT,
    output reg               US_OUT_TAG,
    // Valid reader
    input  wire              GV_IN_TAG,
    output reg               GV_OUT,
    // Valid clearer
    input  wire [DATA_W-1:0] SV_IN,
    input  wire              SV_IN_TAG,
    input  wire              SV_CTRL,
    output reg  [DATA_W-1:0] SV_OUT,
    output reg               SV_OUT_TAG
);

    localparam CW = `VTR_CNT_W;

    // Ratios below two fall back to two
    localparam DS_KK = (DS_K < 2) ? 2 : DS_K;
    localparam US_KK = (US_K < 2) ? 2 : US_K;
    localparam [CW-1:0] DS_LAST = DS_KK - 1;
    localparam [CW-1:0] US_LAST = US_KK - 1;

    // Latency below one falls back to one
    localparam LAT = (DLY_LAT < 1) ? 1 : DLY_LAT;

    // Shared phase counter step, wrapping after the last phase
    function [CW-1:0] next_phase;
        input [CW-1:0] cur;
        input [CW-1:0] last;
        begin
            if (cur == last)
                next_phase = `VTR_CNT_RST;
            else
                next_phase = cur + 8'h01;
        end
    endfunction

    // Delay line
    // The last of the LAT registers is the buffer head, so the buffer
    // costs no extra latency while the reader keeps up.
    wire              dly_adv;
    wire [DATA_W:0]   dly_tail;
    wire              buf_rdy;
    wire [DATA_W:0]   buf_out;

    // Chain advances only on enabled edges the buffer can absorb
    assign dly_adv = CE & buf_rdy;

    generate
        if (LAT == 1)
        begin : g_direct
            // Single stage is the buffer head itself
            assign dly_tail = {DLY_IN_TAG, DLY_IN};
        end
        else
        begin : g_chain
            reg [DATA_W-1:0] dly_data_q [0:LAT-2];
            reg [LAT-2:0]    dly_tag_q;
            integer          i;

            // Shift data and tags together, tags start clear
            always @(posedge CLK_SYS)
            begin
                if (!RST_B)
                begin
                    dly_tag_q <= {(LAT-1){1'b0}};
                    for (i = 0; i < LAT - 1; i = i + 1)
                        dly_data_q[i] <= `VTR_ZERO_W;
                end
                else if (dly_adv)
                begin
                    dly_data_q[0] <= DLY_IN;
                    dly_tag_q[0]  <= DLY_IN_TAG;
                    for (i = 1; i < LAT - 1; i = i + 1)
                    begin
                        dly_data_q[i] <= dly_data_q[i-1];
                        dly_tag_q[i]  <= dly_tag_q[i-1];
                    end
                end
            end

            assign dly_tail = {dly_tag_q[LAT-2], dly_data_q[LAT-2]};
        end
    endgenerate

    // Output buffer absorbs reader stalls without losing a sample
    vtr_buf2 #(
        .W (DATA_W + 1)
    ) u_buf (
        .clk       (CLK_SYS),
        .rst_n     (RST_B),
        .ce        (CE),
        .in_valid  (1'b1),
        .in_ready  (buf_rdy),
        .in_data   (dly_tail),
        .out_valid (DLY_OUT_AVAIL),
        .out_ready (DLY_OUT_RDY),
        .out_data  (buf_out)
    );

    // Delay line outputs, tag stays clear until filled
    assign DLY_IN_RDY  = buf_rdy;
    assign DLY_OUT     = buf_out[DATA_W-1:0];
    assign DLY_OUT_TAG = buf_out[DATA_W];

    // Single register stage
    // Reset input reloads the initial value on an enabled edge; with
    // the keep option invalid samples leave the output untouched.
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            REG_OUT     <= REG_INIT;
            REG_OUT_TAG <= 1'b1;
        end
        else if (CE)
        begin
            if (REG_CLR)
            begin
                REG_OUT     <= REG_INIT;
                REG_OUT_TAG <= 1'b1;
            end
            else if (!(REG_KEEP && !REG_IN_TAG))
            begin
                REG_OUT     <= REG_IN;
                REG_OUT_TAG <= REG_IN_TAG;
            end
        end
    end

    // Down-sampler
    reg  [CW-1:0] ds_cnt_q;
    wire          ds_last;

    assign ds_last = (ds_cnt_q == DS_LAST);

    // Input phase counter, one step per input sample
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
            ds_cnt_q <= `VTR_CNT_RST;
        else if (CE)
            ds_cnt_q <= next_phase(ds_cnt_q, DS_LAST);
    end

    // Capture every k-th input and hold it for k input periods
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            DS_OUT     <= `VTR_ZERO_W;
            DS_OUT_TAG <= DS_ZERO;
            DS_OUT_STB <= 1'b0;
        end
        else if (CE)
        begin
            DS_OUT_STB <= ds_last;   // Marks a new output sample
            if (ds_last)
            begin
                DS_OUT     <= DS_IN;
                DS_OUT_TAG <= DS_IN_TAG;
            end
        end
    end

    // Up-sampler
    reg  [CW-1:0] us_cnt_q;
    wire [CW-1:0] us_cnt_d;
    wire          us_first;

    assign us_cnt_d = next_phase(us_cnt_q, US_LAST);
    assign us_first = (us_cnt_q == `VTR_CNT_RST);

    // Output phase counter, one step per output sample
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
            us_cnt_q <= `VTR_CNT_RST;
        else if (CE)
            us_cnt_q <= us_cnt_d;
    end

    // Phase zero takes the input, later phases copy or send zero
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            US_OUT     <= `VTR_ZERO_W;
            US_OUT_TAG <= 1'b0;
            US_IN_TAKE <= 1'b1;        // First enabled edge takes input
        end
        else if (CE)
        begin
            US_IN_TAKE <= (us_cnt_d == `VTR_CNT_RST);
            if (us_first)
            begin
                US_OUT     <= US_IN;
                US_OUT_TAG <= US_IN_TAG;
            end
            else if (!US_COPY)
                US_OUT <= `VTR_ZERO_W;
            // With copy the held sample simply stays
        end
    end

    // Valid reader
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
            GV_OUT <= 1'b0;
        else if (CE)
            GV_OUT <= GV_IN_TAG;
    end

    // Valid clearer, can only drop the tag
    always @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            SV_OUT     <= `VTR_ZERO_W;
            SV_OUT_TAG <= 1'b0;
        end
        else if (CE)
        begin
            SV_OUT     <= SV_IN;
            SV_OUT_TAG <= SV_IN_TAG & SV_CTRL;
        end
    end

endmodule

// [vtr_stages_tb.sv]
// Purpose: Self-checking random run of the valid-tagged stages
// Assumes: Keep-valid and zero-initial on, ratios 2, copy on
// Notes:   Models update on each rising edge
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
    $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module vtr_stages_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [15:0] INIT = 16'h00A5;
    logic        clk_sys = 1'b0, rst_b, ce, rdy, reg_tag, reg_clr, ds_tag, us_tag;
    logic        gv_tag, sv_tag, sv_ctrl, in_rdy, avail, dly_tag, reg_ot, ds_ot;
    logic        ds_stb, take, us_ot, gv_out, sv_ot, e_regt, e_dst, e_ust, e_gv, e_svt;
    logic [15:0] dly_in, reg_in, ds_in, us_in, sv_in, dly_out, reg_out, ds_out;
    logic [15:0] us_out, sv_out, e_reg, e_ds, e_us, e_sv, exp_d;
    logic [15:0] q[$];
    bit          armed, seen_full;
    int          fails = 0, checks = 0, got, cds, cus;

    // Ratio phase counter
    function automatic int step(int c);
        return (c + 1) % 2;
    endfunction

    // Counts and verdict
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always #10 clk_sys = ~clk_sys;

    vtr_sink sink_u (.clk(clk_sys), .rst_b(rst_b), .rdy(rdy));

    vtr_stages #(.REG_INIT(INIT), .REG_KEEP(1'b1), .DS_ZERO(1'b1)) dut_u (
        .CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce), .DLY_IN(dly_in), .DLY_IN_TAG(1'b1),
        .DLY_IN_RDY(in_rdy), .DLY_OUT(dly_out), .DLY_OUT_TAG(dly_tag),
        .DLY_OUT_AVAIL(avail), .DLY_OUT_RDY(rdy), .REG_IN(reg_in), .REG_IN_TAG(reg_tag),
        .REG_CLR(reg_clr), .REG_OUT(reg_out), .REG_OUT_TAG(reg_ot), .DS_IN(ds_in),
        .DS_IN_TAG(ds_tag), .DS_OUT(ds_out), .DS_OUT_TAG(ds_ot), .DS_OUT_STB(ds_stb),
        .US_IN(us_in), .US_IN_TAG(us_tag), .US_IN_TAKE(take), .US_OUT(us_out),
        .US_OUT_TAG(us_ot), .GV_IN_TAG(gv_tag), .GV_OUT(gv_out), .SV_IN(sv_in),
        .SV_IN_TAG(sv_tag), .SV_CTRL(sv_ctrl), .SV_OUT(sv_out), .SV_OUT_TAG(sv_ot)
    );

    // Reference models and delay scoreboard
    always @(posedge clk_sys)
    begin
        if (armed)
        begin
            `CHK({reg_ot, reg_out}, {e_regt, e_reg})
            `CHK({ds_ot, ds_out}, {e_dst, e_ds})
            `CHK({us_ot, us_out}, {e_ust, e_us})
            `CHK(gv_out, e_gv)
            `CHK({sv_ot, sv_out}, {e_svt, e_sv})
        end
        armed = 1'b1;
        if (!in_rdy)
            seen_full = 1'b1;
        if (!rst_b)
        begin
            {e_regt, e_reg, e_dst, e_ds, e_ust, e_us} = {1'b1, INIT, 1'b1, 33'h0};
            {e_gv, e_svt, e_sv} = 18'h0;
            {cds, cus, got} = 96'h0;
            q.delete();
        end
        else if (ce)
        begin
            if (reg_clr)
                {e_regt, e_reg} = {1'b1, INIT};
            else if (reg_tag)
                {e_regt, e_reg} = {1'b1, reg_in};
            if (cds == 1)
                {e_dst, e_ds} = {ds_tag, ds_in};
            if (cus == 0)
                {e_ust, e_us} = {us_tag, us_in};
            cds = step(cds);
            cus = step(cus);
            e_gv = gv_tag;
            {e_svt, e_sv} = {sv_tag & sv_ctrl, sv_in};
            if (in_rdy)
                q.push_back(dly_in);
            if (avail && rdy && dly_tag)
            begin
                exp_d = q.pop_front();
                `CHK(dly_out, exp_d)
                got++;
            end
            else if (avail && rdy)
                `CHK(got, 0)
        end
    end

    // Reset, random stimulus with a mid-run reset
    initial
    begin
        {rst_b, reg_tag, reg_clr, ds_tag, us_tag, gv_tag, sv_tag, sv_ctrl} = 8'h00;
        {dly_in, reg_in, ds_in, us_in, sv_in} = 80'h0;
        ce = 1'b1;
        void'($urandom(80652));
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        // Look at the strobe mid-cycle, where it has settled
        for (int i = 0; i < 9 && ds_stb !== 1'b1; i++)
            @(negedge clk_sys);
        `CHK(ds_stb, 1'b1)
        if (ds_stb !== 1'b1)
            end_sim;
        for (int i = 0; i < 700; i++)
        begin
            @(posedge clk_sys);
            if (rst_b && ce && in_rdy)
                dly_in <= 16'($urandom);
            rst_b <= (i < 300 || i > 302);
            ce <= ($urandom_range(7, 0) != 0);
            reg_clr <= ($urandom_range(7, 0) == 0);
            {reg_in, ds_in, us_in, sv_in} <= {$urandom, $urandom};
            {reg_tag, ds_tag, us_tag, gv_tag, sv_tag, sv_ctrl} <= 6'($urandom);
        end
        `CHK(seen_full, 1'b1)
        `CHK(got > 100, 1'b1)
        end_sim;
    end
endmodule
